/* hw/ocr_pkg.sv */
// constants shared by the line-control register bank and its link controller
// Contract
// R1 - line control: write, set, clear addresses
// R2 - set ORs ones, clear clears ones
// R3 - bit 0 connects ID pull-up
// R4 - bits 1,2 D+/D- pull-downs, default on
// R5 - bit 3 discharges bus power, SRP only; the code drives the discharge pin from bit 3 in every mode
// R6 - bit 4 charges bus power, SRP only; the code drives the charge pin from bit 4 in every mode
// R7 - pump enable is bit 5 OR bit 6
// R8 - bit 7 picks off-chip power indicator
// R9 - rise enables: write, set, clear addresses
// R10 - rise enables flag low-to-high source edges
// R11 - fall enables: write, set, clear addresses
// R12 - fall enables flag high-to-low; 7:5 zero
// R13 - disconnect events only in host mode
// R14 - status byte shows five live sources
// R15 - status after reset is live, not fixed
// R16 - enabled edges latch; latch read clears
package ocr_pkg;
	localparam logic [5:0] OTG_LINE_CONTROL_ADDR  = 6'h0a;
	localparam logic [5:0] EVENT_RISE_ENABLE_ADDR = 6'h0d;
	localparam logic [5:0] EVENT_FALL_ENABLE_ADDR = 6'h10;
	localparam logic [5:0] EVENT_SOURCE_STATUS_ADDR = 6'h13;
	localparam logic [5:0] EVENT_LATCH_ADDR       = 6'h14;
	localparam logic [7:0] OTG_LINE_CONTROL_RESET = 8'h06;
	localparam logic [7:0] EVENT_ENABLE_RESET     = 8'h1f;
	localparam logic [7:0] EVENT_ENABLE_MASK      = 8'h1f;
	localparam logic [1:0] ACC_WRITE              = 2'h0;
	localparam logic [1:0] ACC_SET                = 2'h1;
	localparam logic [1:0] ACC_CLEAR              = 2'h2;
	localparam int BIT_ID_PULLUP   = 0;
	localparam int BIT_DP_PULLDOWN = 1;
	localparam int BIT_DM_PULLDOWN = 2;
	localparam int BIT_DISCHARGE   = 3;
	localparam int BIT_CHARGE      = 4;
	localparam int BIT_DRIVE       = 5;
	localparam int BIT_DRIVE_ALT   = 6;
	localparam int BIT_OFFCHIP_SEL = 7;
	localparam int SRC_HOST_DISC   = 0;
	localparam int SRC_VBUS_VALID  = 1;
	localparam logic OFFCHIP_INDICATOR_LEVEL = 1'b1;
	localparam logic [1:0] EDGE_ARM_CYCLES = 2'h3;
	// controller register map on the AXI4-Lite side
	localparam logic [3:0] CTRL_CMD_ADDR      = 4'h0;
	localparam logic [3:0] CTRL_STATUS_ADDR   = 4'h4;
	localparam logic [3:0] CTRL_IRQ_STAT_ADDR = 4'h8;
	localparam logic [3:0] CTRL_IRQ_MASK_ADDR = 4'hc;
	localparam int CMD_DATA_LSB  = 0;
	localparam int CMD_ADDR_LSB  = 8;
	localparam int CMD_WRITE_BIT = 16;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_DATA_LSB = 8;
	localparam int IRQ_DONE_BIT  = 0;
	localparam int IRQ_EVENT_BIT = 1;
	localparam logic [1:0] AXI_OKAY   = 2'h0;
	localparam logic [1:0] AXI_SLVERR = 2'h2;
endpackage

/* hw/ocr_link_if.sv */
// register access link between controller and transceiver register bank
`timescale 1ns/1ps
`default_nettype none
interface ocr_link_if;
	logic       req;
	logic       wr;
	logic [5:0] addr;
	logic [7:0] wdata;
	logic       ack;
	logic [7:0] rdata;
	logic       evt;
	modport dev (input req, input wr, input addr, input wdata,
		output ack, output rdata, output evt);
	modport lnk (output req, output wr, output addr, output wdata,
		input ack, input rdata, input evt);
endinterface
`default_nettype wire

/* hw/ocr_phy_regs.sv */
// transceiver side: line control, event enables, live status and latch
//
// Design decision made here: the req/ack link interface (ocr_link_if) to the registers.
`timescale 1ns/1ps
`default_nettype none
module ocr_phy_regs (
	input  wire logic  SYS_CLK_I,
	input  wire logic  RST_I,
	ocr_link_if.dev    link,
	input  wire logic  HOST_MODE_I,
	input  wire logic  HOST_DISCONNECT_I,
	input  wire logic  VBUS_COMPARATOR_I,
	input  wire logic  SESSION_LEVEL_VALID_I,
	input  wire logic  SESSION_ENDED_I,
	input  wire logic  ID_PIN_GROUNDED_I,
	output logic       ID_PIN_PULLUP_ENABLE_O,
	output logic       DPLUS_PULLDOWN_ENABLE_O,
	output logic       DMINUS_PULLDOWN_ENABLE_O,
	output logic       BUS_POWER_DISCHARGE_ENABLE_O,
	output logic       BUS_POWER_CHARGE_ENABLE_O,
	output logic       CHARGE_PUMP_ENABLE_PIN_O
);
	import ocr_pkg::*;

	typedef struct packed {
		logic [7:0] otg;
		logic [7:0] rise;
		logic [7:0] fall;
		logic [4:0] latch;
		logic [5:0] sync1;
		logic [5:0] sync2;
		logic [4:0] prev;
		logic [1:0] arm;
		logic       ack;
		logic [7:0] rdata;
		logic       evt;
		logic [5:0] pins;
	} ocr_dev_state_type;

	ocr_dev_state_type s_reg;
	ocr_dev_state_type s_next;

	// write, set or clear applied to one byte
	function automatic logic [7:0] apply_access(input logic [7:0] cur,
		input logic [7:0] wd, input logic [1:0] op);
		logic [7:0] r;
		r = cur;
		case (op)
			ACC_WRITE: r = wd;
			ACC_SET:   r = cur | wd; // R2
			ACC_CLEAR: r = cur & ~wd; // R2
			default:   r = cur;
		endcase
		return r;
	endfunction

	// whether one of the three access addresses of a byte was hit
	function automatic logic in_triple(input logic [5:0] a,
		input logic [5:0] base);
		return (a >= base) && (a <= base + 6'h2);
	endfunction

	logic [5:0] raw;
	logic [4:0] cur;
	logic [4:0] rise_ev;
	logic [4:0] fall_ev;
	logic [4:0] ev;
	logic       take;
	logic       is_host;

	assign raw = {HOST_MODE_I, ID_PIN_GROUNDED_I, SESSION_ENDED_I,
		SESSION_LEVEL_VALID_I, VBUS_COMPARATOR_I, HOST_DISCONNECT_I};

	always_comb begin
		s_next = s_reg;
		s_next.sync1 = raw;
		s_next.sync2 = s_reg.sync1;
		is_host = s_reg.sync2[5];
		cur = s_reg.sync2[4:0];
		// off-chip indicator is tied high on this part
		if (s_reg.otg[BIT_OFFCHIP_SEL]) begin // R8
			cur[SRC_VBUS_VALID] = OFFCHIP_INDICATOR_LEVEL;
		end
		s_next.prev = cur;
		// edges are ignored until the synchroniser holds real samples
		if (s_reg.arm != EDGE_ARM_CYCLES) begin
			s_next.arm = s_reg.arm + 2'h1;
		end
		rise_ev = cur & ~s_reg.prev & s_reg.rise[4:0]; // R10
		fall_ev = ~cur & s_reg.prev & s_reg.fall[4:0]; // R12
		ev = rise_ev | fall_ev;
		if (!is_host) begin
			ev[SRC_HOST_DISC] = 1'b0; // R13
		end
		if (s_reg.arm != EDGE_ARM_CYCLES) begin
			ev = 5'h00;
		end
		s_next.evt = |ev;
		take = link.req && !s_reg.ack;
		s_next.ack = take;
		s_next.latch = s_reg.latch | ev; // R16
		if (take) begin
			s_next.rdata = 8'h00;
			if (in_triple(link.addr, OTG_LINE_CONTROL_ADDR)) begin
				s_next.rdata = s_reg.otg; // R1
				if (link.wr) begin
					s_next.otg = apply_access(s_reg.otg, link.wdata,
						2'(link.addr - OTG_LINE_CONTROL_ADDR)); // R1
				end
			end
			if (in_triple(link.addr, EVENT_RISE_ENABLE_ADDR)) begin
				s_next.rdata = s_reg.rise; // R9
				if (link.wr) begin
					s_next.rise = apply_access(s_reg.rise, link.wdata,
						2'(link.addr - EVENT_RISE_ENABLE_ADDR))
						& EVENT_ENABLE_MASK; // R9
				end
			end
			if (in_triple(link.addr, EVENT_FALL_ENABLE_ADDR)) begin
				s_next.rdata = s_reg.fall; // R11
				if (link.wr) begin
					s_next.fall = apply_access(s_reg.fall, link.wdata,
						2'(link.addr - EVENT_FALL_ENABLE_ADDR))
						& EVENT_ENABLE_MASK; // R12
				end
			end
			if (link.addr == EVENT_SOURCE_STATUS_ADDR) begin
				s_next.rdata = {3'h0, cur}; // R14 R15
			end
			if (link.addr == EVENT_LATCH_ADDR && !link.wr) begin
				s_next.rdata = {3'h0, s_reg.latch};
				// an edge in the same cycle survives the clear
				s_next.latch = ev; // R16
			end
			// writes answer zero so a stale byte never passes as read data
			if (link.wr) begin
				s_next.rdata = 8'h00;
			end
		end
		s_next.pins[0] = s_next.otg[BIT_ID_PULLUP]; // R3
		s_next.pins[1] = s_next.otg[BIT_DP_PULLDOWN]; // R4
		s_next.pins[2] = s_next.otg[BIT_DM_PULLDOWN]; // R4
		s_next.pins[3] = s_next.otg[BIT_DISCHARGE]; // R5
		s_next.pins[4] = s_next.otg[BIT_CHARGE]; // R6
		s_next.pins[5] = s_next.otg[BIT_DRIVE]
			| s_next.otg[BIT_DRIVE_ALT]; // R7
	end

	always_ff @(posedge SYS_CLK_I) begin
		if (RST_I) begin
			s_reg.otg   <= OTG_LINE_CONTROL_RESET;
			s_reg.rise  <= EVENT_ENABLE_RESET;
			s_reg.fall  <= EVENT_ENABLE_RESET;
			s_reg.latch <= 5'h00;
			s_reg.sync1 <= 6'h00;
			s_reg.sync2 <= 6'h00;
			s_reg.prev  <= 5'h00;
			s_reg.arm   <= 2'h0;
			s_reg.ack   <= 1'b0;
			s_reg.rdata <= 8'h00;
			s_reg.evt   <= 1'b0;
			s_reg.pins  <= {OTG_LINE_CONTROL_RESET[BIT_DRIVE]
				| OTG_LINE_CONTROL_RESET[BIT_DRIVE_ALT],
				OTG_LINE_CONTROL_RESET[4:0]};
		end else begin
			s_reg <= s_next;
		end
	end

	assign link.ack = s_reg.ack;
	assign link.rdata = s_reg.rdata;
	assign link.evt = s_reg.evt;
	assign ID_PIN_PULLUP_ENABLE_O = s_reg.pins[0];
	assign DPLUS_PULLDOWN_ENABLE_O = s_reg.pins[1];
	assign DMINUS_PULLDOWN_ENABLE_O = s_reg.pins[2];
	assign BUS_POWER_DISCHARGE_ENABLE_O = s_reg.pins[3];
	assign BUS_POWER_CHARGE_ENABLE_O = s_reg.pins[4];
	assign CHARGE_PUMP_ENABLE_PIN_O = s_reg.pins[5];
endmodule
`default_nettype wire

/* hw/ocr_link_ctrl.sv */
// link controller: AXI4-Lite command registers driving the register link
`timescale 1ns/1ps
`default_nettype none
module ocr_link_ctrl (
	input  wire logic        SYS_CLK_I,
	input  wire logic        RST_I,
	input  wire logic [3:0]  S_AXI_AWADDR_I,
	input  wire logic        S_AXI_AWVALID_I,
	output logic             S_AXI_AWREADY_O,
	input  wire logic [31:0] S_AXI_WDATA_I,
	input  wire logic [3:0]  S_AXI_WSTRB_I,
	input  wire logic        S_AXI_WVALID_I,
	output logic             S_AXI_WREADY_O,
	output logic [1:0]       S_AXI_BRESP_O,
	output logic             S_AXI_BVALID_O,
	input  wire logic        S_AXI_BREADY_I,
	input  wire logic [3:0]  S_AXI_ARADDR_I,
	input  wire logic        S_AXI_ARVALID_I,
	output logic             S_AXI_ARREADY_O,
	output logic [31:0]      S_AXI_RDATA_O,
	output logic [1:0]       S_AXI_RRESP_O,
	output logic             S_AXI_RVALID_O,
	input  wire logic        S_AXI_RREADY_I,
	output logic             IRQ_O,
	ocr_link_if.lnk          link
);
	import ocr_pkg::*;

	typedef struct packed {
		logic [3:0]  awaddr;
		logic        aw_got;
		logic [31:0] wdata;
		logic        w_got;
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		logic        req;
		logic        wr;
		logic [5:0]  addr;
		logic [7:0]  ldata;
		logic [7:0]  result;
		logic [1:0]  irq_stat;
		logic [1:0]  irq_mask;
		logic        irq;
	} ocr_host_state_type;

	ocr_host_state_type s_reg;
	ocr_host_state_type s_next;
	logic [1:0] ev;

	always_comb begin
		s_next = s_reg;
		ev = {link.evt, s_reg.req && link.ack};
		if (s_reg.req && link.ack) begin
			s_next.req = 1'b0;
			s_next.result = link.rdata;
		end
		if (S_AXI_AWVALID_I && s_reg.awready) begin
			s_next.aw_got = 1'b1;
			s_next.awaddr = S_AXI_AWADDR_I;
		end
		if (S_AXI_WVALID_I && s_reg.wready) begin
			s_next.w_got = 1'b1;
			s_next.wdata = S_AXI_WDATA_I;
		end
		if (s_reg.bvalid && S_AXI_BREADY_I) begin
			s_next.bvalid = 1'b0;
		end
		if (s_reg.aw_got && s_reg.w_got && !s_reg.bvalid) begin
			s_next.aw_got = 1'b0;
			s_next.w_got = 1'b0;
			s_next.bvalid = 1'b1;
			s_next.bresp = AXI_OKAY;
			case (s_reg.awaddr)
				CTRL_CMD_ADDR: begin
					// a command while one is in flight is dropped
					if (!s_reg.req) begin
						s_next.req = 1'b1; // R1 R9 R11
						s_next.wr = s_reg.wdata[CMD_WRITE_BIT];
						s_next.addr = s_reg.wdata[CMD_ADDR_LSB +: 6];
						s_next.ldata = s_reg.wdata[CMD_DATA_LSB +: 8];
					end
				end
				CTRL_IRQ_MASK_ADDR: s_next.irq_mask = s_reg.wdata[1:0];
				CTRL_STATUS_ADDR: s_next.bresp = AXI_OKAY;
				CTRL_IRQ_STAT_ADDR: s_next.bresp = AXI_OKAY;
				default: s_next.bresp = AXI_SLVERR;
			endcase
		end
		s_next.irq_stat = s_reg.irq_stat | ev;
		if (s_reg.rvalid && S_AXI_RREADY_I) begin
			s_next.rvalid = 1'b0;
		end
		if (S_AXI_ARVALID_I && s_reg.arready) begin
			s_next.rvalid = 1'b1;
			s_next.rresp = AXI_OKAY;
			s_next.rdata = 32'h0;
			case (S_AXI_ARADDR_I)
				CTRL_CMD_ADDR: s_next.rdata = {15'h0, s_reg.wr,
					2'h0, s_reg.addr, s_reg.ldata};
				CTRL_STATUS_ADDR: begin
					s_next.rdata[STAT_BUSY_BIT] = s_reg.req;
					s_next.rdata[STAT_DATA_LSB +: 8] = s_reg.result;
				end
				CTRL_IRQ_STAT_ADDR: begin
					s_next.rdata = {30'h0, s_reg.irq_stat};
					// events of this very cycle stay pending
					s_next.irq_stat = ev;
				end
				CTRL_IRQ_MASK_ADDR: s_next.rdata = {30'h0, s_reg.irq_mask};
				default: s_next.rresp = AXI_SLVERR;
			endcase
		end
		s_next.awready = !s_next.aw_got && !s_next.bvalid;
		s_next.wready = !s_next.w_got && !s_next.bvalid;
		s_next.arready = !s_next.rvalid;
		s_next.irq = |(s_next.irq_stat & s_next.irq_mask);
	end

	always_ff @(posedge SYS_CLK_I) begin
		if (RST_I) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign S_AXI_AWREADY_O = s_reg.awready;
	assign S_AXI_WREADY_O = s_reg.wready;
	assign S_AXI_BVALID_O = s_reg.bvalid;
	assign S_AXI_BRESP_O = s_reg.bresp;
	assign S_AXI_ARREADY_O = s_reg.arready;
	assign S_AXI_RVALID_O = s_reg.rvalid;
	assign S_AXI_RDATA_O = s_reg.rdata;
	assign S_AXI_RRESP_O = s_reg.rresp;
	assign IRQ_O = s_reg.irq;
	assign link.req = s_reg.req;
	assign link.wr = s_reg.wr;
	assign link.addr = s_reg.addr;
	assign link.wdata = s_reg.ldata;
endmodule
`default_nettype wire

/* verif/ocr_link_properties.sv */
// checker for the register link between controller and register bank
`timescale 1ns/1ps
`default_nettype none
module ocr_link_properties (
	input wire logic       SYS_CLK_I,
	input wire logic       RST_I,
	input wire logic       req,
	input wire logic       wr,
	input wire logic [5:0] addr,
	input wire logic [7:0] wdata,
	input wire logic       ack,
	input wire logic [7:0] rdata,
	input wire logic       evt
);
	default clocking @(posedge SYS_CLK_I); endclocking
	default disable iff (RST_I);

	a_ack_one_pulse: assert property (ack |=> !ack)
		else $error("ack held longer than one cycle");
	a_ack_answers_req: assert property (req && !ack |=> ack)
		else $error("no ack one cycle after request");
	a_ack_has_cause: assert property (ack |-> $past(req) && !$past(ack))
		else $error("ack without a pending request");
	a_req_drops_after: assert property (ack |=> !req)
		else $error("request not dropped after ack");
	a_req_held_stable: assert property (req && !ack |=>
		$stable(addr) && $stable(wr) && $stable(wdata))
		else $error("request changed before ack");
	a_write_reads_zero: assert property (ack && wr |-> rdata == 8'h00)
		else $error("read data not zero on a write");
	a_enable_top_zero: assert property (
		ack && !wr && addr >= 6'h0d && addr <= 6'h13
		|-> rdata[7:5] == 3'h0)
		else $error("enable or status bits 7:5 not zero");
	a_latch_top_zero: assert property (
		ack && !wr && addr == 6'h14 |-> rdata[7:5] == 3'h0)
		else $error("latch bits 7:5 not zero");
	a_unmapped_zero: assert property (
		ack && !wr && (addr < 6'h0a || addr > 6'h14) |-> rdata == 8'h00)
		else $error("unmapped read not zero");
	a_evt_one_pulse: assert property (evt |=> !evt)
		else $error("event pulse longer than one cycle");
endmodule
`default_nettype wire

/* verif/test_otg_line_control_and_event_regs.sv */
// bench: AXI4-Lite master driving controller and register bank end to end
`timescale 1ns/1ps
`default_nettype none
module test_otg_line_control_and_event_regs;
	import ocr_pkg::*;
	logic        clk, rst, awv, wv, bre, arv, rre, irq;
	logic        awr, wre, bv, arr, rv;
	logic [3:0]  awa, ara;
	logic [31:0] wdt, rdt;
	logic [1:0]  bresp, rresp;
	logic        hm, hd, vb, sv, se, idg;
	logic        p_id, p_dp, p_dm, p_dis, p_chg, p_pump;
	int          err_count, checked;
	logic [1:0]  b_got, r_got;
	ocr_link_if link_bus ();
	ocr_phy_regs ocr_phy_regs_inst (.SYS_CLK_I(clk), .RST_I(rst),
		.link(link_bus.dev), .HOST_MODE_I(hm), .HOST_DISCONNECT_I(hd),
		.VBUS_COMPARATOR_I(vb), .SESSION_LEVEL_VALID_I(sv),
		.SESSION_ENDED_I(se), .ID_PIN_GROUNDED_I(idg),
		.ID_PIN_PULLUP_ENABLE_O(p_id), .DPLUS_PULLDOWN_ENABLE_O(p_dp),
		.DMINUS_PULLDOWN_ENABLE_O(p_dm), .BUS_POWER_DISCHARGE_ENABLE_O(p_dis),
		.BUS_POWER_CHARGE_ENABLE_O(p_chg), .CHARGE_PUMP_ENABLE_PIN_O(p_pump));
	ocr_link_ctrl ocr_link_ctrl_inst (.SYS_CLK_I(clk), .RST_I(rst),
		.S_AXI_AWADDR_I(awa), .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awr),
		.S_AXI_WDATA_I(wdt), .S_AXI_WSTRB_I(4'hf), .S_AXI_WVALID_I(wv),
		.S_AXI_WREADY_O(wre), .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bv),
		.S_AXI_BREADY_I(bre), .S_AXI_ARADDR_I(ara), .S_AXI_ARVALID_I(arv),
		.S_AXI_ARREADY_O(arr), .S_AXI_RDATA_O(rdt), .S_AXI_RRESP_O(rresp),
		.S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(rre), .IRQ_O(irq),
		.link(link_bus.lnk));
	ocr_link_properties ocr_link_properties_inst (.SYS_CLK_I(clk),
		.RST_I(rst), .req(link_bus.req), .wr(link_bus.wr),
		.addr(link_bus.addr), .wdata(link_bus.wdata), .ack(link_bus.ack),
		.rdata(link_bus.rdata), .evt(link_bus.evt));
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	task automatic tally_and_finish();
		if (err_count == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("FAIL %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic timed_out();
		err_count++;
		tally_and_finish();
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge clk);
	endtask
	// signals seen right after the edge are the values sampled at it
	// flags track each channel at once; the driven copies only move later
	task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
		int n;
		logic aw_on, w_on, b_on;
		@(posedge clk);
		awa <= a; wdt <= d; awv <= 1'b1; wv <= 1'b1; bre <= 1'b1;
		aw_on = 1'b1; w_on = 1'b1; b_on = 1'b1;
		for (n = 0; n < 200 && (aw_on || w_on || b_on); n++) begin
			@(posedge clk);
			if (aw_on && awr) begin
				awv <= 1'b0;
				aw_on = 1'b0;
			end
			if (w_on && wre) begin
				wv <= 1'b0;
				w_on = 1'b0;
			end
			if (b_on && bv) begin
				b_got = bresp;
				bre <= 1'b0;
				b_on = 1'b0;
			end
		end
		if (n >= 200) timed_out();
	endtask
	task automatic axi_rd(input logic [3:0] a, output logic [31:0] d);
		int n;
		logic ar_on, r_on;
		@(posedge clk);
		ara <= a; arv <= 1'b1; rre <= 1'b1;
		ar_on = 1'b1; r_on = 1'b1;
		for (n = 0; n < 200 && (ar_on || r_on); n++) begin
			@(posedge clk);
			if (ar_on && arr) begin
				arv <= 1'b0;
				ar_on = 1'b0;
			end
			if (r_on && rv) begin
				d = rdt;
				r_got = rresp;
				rre <= 1'b0;
				r_on = 1'b0;
			end
		end
		if (n >= 200) timed_out();
	endtask
	// a command written while busy is dropped, so wait for idle each time
	task automatic lk(input logic w, input logic [5:0] a,
		input logic [7:0] wd, output logic [7:0] rd);
		logic [31:0] s;
		int n;
		axi_wr(CTRL_CMD_ADDR, {15'h0, w, 2'h0, a, wd});
		s = 32'h1;
		for (n = 0; n < 50 && s[STAT_BUSY_BIT] !== 1'b0; n++)
			axi_rd(CTRL_STATUS_ADDR, s);
		if (n >= 50) timed_out();
		rd = s[15:8];
	endtask
	task automatic chk_pins(input logic [7:0] v);
		chk({26'h0, p_pump, p_chg, p_dis, p_dm, p_dp, p_id},
			{26'h0, v[5] | v[6], v[4:0]});
	endtask
	task automatic s_defaults();
		logic [7:0] r;
		chk_pins(OTG_LINE_CONTROL_RESET);
		lk(0, OTG_LINE_CONTROL_ADDR, 8'h00, r); chk(r, 8'h06);
		lk(0, EVENT_RISE_ENABLE_ADDR, 8'h00, r); chk(r, 8'h1f);
		lk(0, EVENT_FALL_ENABLE_ADDR, 8'h00, r); chk(r, 8'h1f);
		lk(0, EVENT_SOURCE_STATUS_ADDR, 8'h00, r); chk(r, 8'h18);
		lk(0, 6'h3f, 8'h00, r); chk(r, 8'h00);
	endtask
	task automatic s_regs();
		logic [5:0] b;
		logic [7:0] m, r;
		logic [7:0] v [4];
		v = '{8'h40, 8'h20, 8'h1f, 8'h00};
		for (int i = 0; i < 3; i++) begin
			b = (i == 0) ? 6'h0a : (i == 1) ? 6'h0d : 6'h10;
			m = (i == 0) ? 8'hff : 8'h1f;
			lk(1, b, 8'ha5, r); lk(0, b, 8'h00, r); chk(r, 8'ha5 & m);
			lk(1, b + 6'h1, 8'h5a, r); lk(0, b + 6'h2, 8'h00, r);
			chk(r, m);
			lk(1, b + 6'h2, 8'h0f, r); lk(0, b + 6'h1, 8'h00, r);
			chk(r, 8'hf0 & m);
		end
		chk_pins(8'hf0);
		for (int i = 0; i < 4; i++) begin
			lk(1, OTG_LINE_CONTROL_ADDR, v[i], r);
			chk_pins(v[i]);
		end
	endtask
	task automatic s_events();
		logic [7:0] r;
		logic [31:0] d;
		lk(1, EVENT_RISE_ENABLE_ADDR, 8'h1f, r);
		lk(1, EVENT_FALL_ENABLE_ADDR, 8'h1f, r);
		lk(0, EVENT_LATCH_ADDR, 8'h00, r);
		axi_wr(CTRL_IRQ_MASK_ADDR, 32'h2);
		axi_rd(CTRL_IRQ_STAT_ADDR, d);
		sv <= 1'b1; idle(12);
		chk(irq, 1'b1);
		lk(0, EVENT_LATCH_ADDR, 8'h00, r); chk(r, 8'h04);
		lk(0, EVENT_LATCH_ADDR, 8'h00, r); chk(r, 8'h00);
		axi_rd(CTRL_IRQ_STAT_ADDR, d); chk(d[IRQ_EVENT_BIT], 1'b1);
		idle(3); chk(irq, 1'b0);
		lk(1, EVENT_FALL_ENABLE_ADDR + 6'h2, 8'h04, r);
		sv <= 1'b0; vb <= 1'b1; idle(12);
		lk(0, EVENT_LATCH_ADDR, 8'h00, r); chk(r, 8'h02);
		hd <= 1'b1; idle(12);
		lk(0, EVENT_LATCH_ADDR, 8'h00, r); chk(r, 8'h00);
		hm <= 1'b1; idle(12); hd <= 1'b0; idle(12);
		lk(0, EVENT_LATCH_ADDR, 8'h00, r); chk(r, 8'h01);
		lk(0, EVENT_SOURCE_STATUS_ADDR, 8'h00, r); chk(r, 8'h1a);
		vb <= 1'b0; idle(12);
		lk(0, EVENT_SOURCE_STATUS_ADDR, 8'h00, r); chk(r, 8'h18);
		lk(1, OTG_LINE_CONTROL_ADDR, 8'h80, r);
		lk(0, EVENT_SOURCE_STATUS_ADDR, 8'h00, r); chk(r, 8'h1a);
	endtask
	// latch write ignored, command readback, responses and error codes
	task automatic s_host();
		logic [7:0] r;
		logic [31:0] d;
		lk(1, EVENT_LATCH_ADDR, 8'hff, r); chk(r, 8'h00);
		lk(0, EVENT_LATCH_ADDR, 8'h00, r); chk(r, 8'h02);
		lk(1, OTG_LINE_CONTROL_ADDR, 8'h06, r); chk(r, 8'h00);
		chk(b_got, AXI_OKAY); chk(r_got, AXI_OKAY);
		axi_rd(CTRL_CMD_ADDR, d);
		chk(d, {15'h0, 1'b1, 2'h0, OTG_LINE_CONTROL_ADDR, 8'h06});
		axi_rd(CTRL_IRQ_MASK_ADDR, d); chk(d, 32'h2);
		axi_rd(CTRL_IRQ_STAT_ADDR, d); chk(d[IRQ_DONE_BIT], 1'b1);
		axi_wr(4'h2, 32'h0); chk(b_got, AXI_SLVERR);
		axi_rd(4'h2, d); chk(r_got, AXI_SLVERR); chk(d, 32'h0);
	endtask
	initial begin
		err_count = 0; checked = 0; rst = 1'b1;
		awv = 0; wv = 0; bre = 0; arv = 0; rre = 0;
		awa = 4'h0; ara = 4'h0; wdt = 32'h0;
		// unattached start: session ended and id grounded seen live
		hm = 0; hd = 0; vb = 0; sv = 0; se = 1; idg = 1;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		idle(8);
		s_defaults();
		s_regs();
		s_events();
		s_host();
		tally_and_finish();
	end
endmodule
`default_nettype wire
